/* common/cbs_pkg.sv */
// shared types and constants of the bus cycle sequencer
package cbs_pkg;

  // instruction groups that the decoder hands to the sequencer
  typedef enum logic [3:0] {
    CLS_SINGLE    = 4'h0,
    CLS_ADD16     = 4'h1,
    CLS_ADD_IDX16 = 4'h2,
    CLS_ADC16     = 4'h3,
    CLS_ALU_REG   = 4'h4,
    CLS_ALU_IMM   = 4'h5,
    CLS_ALU_HL    = 4'h6,
    CLS_ALU_IDX   = 4'h7,
    CLS_BIT_REG   = 4'h8,
    CLS_BIT_HL    = 4'h9,
    CLS_BIT_IDX   = 4'hA,
    CLS_CALL      = 4'hB,
    CLS_CALL_COND = 4'hC
  } cbs_class_t;

  // kind of machine cycle
  typedef enum logic [3:0] {
    K_END    = 4'h0,
    K_FETCH1 = 4'h1,
    K_FETCH2 = 4'h2,
    K_FETCH3 = 4'h3,
    K_RD_OP  = 4'h4,
    K_RD_HL  = 4'h5,
    K_RD_IDX = 4'h6,
    K_INT    = 4'h7,
    K_WR_HI  = 4'h8,
    K_WR_LO  = 4'h9
  } cbs_kind_t;

  // t states, gray along idle, t1, t2, t3; internal state one bit off t3
  typedef enum logic [2:0] {
    TS_IDLE = 3'h0,
    TS_T1   = 3'h1,
    TS_T2   = 3'h3,
    TS_T3   = 3'h2,
    TS_TI   = 3'h6
  } cbs_tstate_t;

  // internal states per group
  localparam logic [3:0] ADD16_TI = 4'h4;
  localparam logic [3:0] IDX16_TI = 4'h4;
  localparam logic [3:0] ALU_IDX_TI = 4'h3;

  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] STACK_STEP = 16'h0001;
  localparam logic [15:0] PTR_STEP = 16'h0001;
  localparam logic [3:0] STEP_RESET = 4'h0;

endpackage

/* rtl/cbs_sequencer.sv */
// per-instruction bus cycle sequencer
// What this block does
// RL1: every instruction opens with a three-state first opcode fetch, read, request, marker and status low.
// RL2: prefixed instructions do a second three-state opcode fetch with the marker low and status high.
// RL3: internal states leave the address invalid, the data bus floating and every strobe high.
// RL4: operand, displacement and data reads take three states with only read and request low.
// RL5: a taken call fetches, reads low and high address, idles once, then writes return high at stack-1 and low at stack-2.
// RL6: a call whose condition is false ends after the fetch and the low address read.
// RL7: indexed arithmetic fetches two opcodes, reads the displacement, idles, then reads at index plus displacement.
// RL8: one t state per clock, the next cycle chosen from the instruction group and the cycle number.
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire cbs_pkg::cbs_class_t instr_class,
  input wire logic cond_true,
  input wire logic use_index_y,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] memory_pointer_pair,
  input wire logic [15:0] index_register_x,
  input wire logic [15:0] index_register_y,
  input wire logic [7:0] data_in,
  output logic instr_ready,
  output logic instr_done,
  output logic [15:0] address,
  output logic address_valid,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic read_strobe_b,
  output logic write_strobe_b,
  output logic memory_request_strobe_b,
  output logic io_request_strobe_b,
  output logic opcode_fetch_marker_b,
  output logic halt_b,
  output logic first_fetch_status_b
);
  typedef struct packed {
    cbs_pkg::cbs_tstate_t t;
    cbs_pkg::cbs_kind_t kind;
    cbs_pkg::cbs_class_t cls;
    logic [3:0] step;
    logic cond;
    logic [15:0] ptr;
    logic [15:0] sp;
    logic [15:0] hl;
    logic [15:0] base;
    logic [7:0] disp;
    logic [15:0] address;
    logic [7:0] data_out;
    logic done;
    logic [8:0] pins;
  } cbs_state_t;

  localparam cbs_state_t STATE_RESET = '{
    t: cbs_pkg::TS_IDLE, kind: cbs_pkg::K_END, cls: cbs_pkg::CLS_SINGLE,
    step: cbs_pkg::STEP_RESET, cond: 1'b0, ptr: cbs_pkg::ADDR_RESET,
    sp: cbs_pkg::ADDR_RESET, hl: cbs_pkg::ADDR_RESET, base: cbs_pkg::ADDR_RESET,
    disp: cbs_pkg::DATA_RESET, address: cbs_pkg::ADDR_RESET,
    data_out: cbs_pkg::DATA_RESET, done: 1'b0, pins: 9'h1FC};

  logic reset_b_meta;
  logic reset_b_sync;
  cbs_state_t s;
  cbs_state_t next_s;
  cbs_state_t next_reg;
  logic [8:0] next_pins;
  logic start;

  // reset is asserted at once and released through two flops
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_b_meta <= 1'b0;
      reset_b_sync <= 1'b0;
    end else begin
      reset_b_meta <= 1'b1;
      reset_b_sync <= reset_b_meta;
    end
  end

  // cycle table: kind of machine cycle i of a group, K_END once it is over
  function automatic cbs_pkg::cbs_kind_t step_kind(cbs_pkg::cbs_class_t c, logic [3:0] i,
                                                    logic cond);
    cbs_pkg::cbs_kind_t k;
    k = cbs_pkg::K_END;
    if (i == 4'h0) begin
      k = cbs_pkg::K_FETCH1; // RL1
    end else begin
      unique case (c)
        cbs_pkg::CLS_SINGLE: k = cbs_pkg::K_END;
        cbs_pkg::CLS_ADD16: if (i <= cbs_pkg::ADD16_TI) k = cbs_pkg::K_INT; // RL3
        cbs_pkg::CLS_ADD_IDX16, cbs_pkg::CLS_ADC16: begin
          if (i == 4'h1) k = cbs_pkg::K_FETCH2; // RL2
          else if (i <= 4'h1 + cbs_pkg::IDX16_TI) k = cbs_pkg::K_INT; // RL3
        end
        cbs_pkg::CLS_ALU_REG: if (i == 4'h1) k = cbs_pkg::K_INT;
        cbs_pkg::CLS_ALU_IMM: if (i == 4'h1) k = cbs_pkg::K_RD_OP; // RL4
        cbs_pkg::CLS_ALU_HL: if (i == 4'h1) k = cbs_pkg::K_RD_HL; // RL4
        cbs_pkg::CLS_ALU_IDX: begin
          if (i == 4'h1) k = cbs_pkg::K_FETCH2; // RL7
          else if (i == 4'h2) k = cbs_pkg::K_RD_OP; // RL7
          else if (i <= 4'h2 + cbs_pkg::ALU_IDX_TI) k = cbs_pkg::K_INT; // RL7
          else if (i == 4'h3 + cbs_pkg::ALU_IDX_TI) k = cbs_pkg::K_RD_IDX; // RL7
        end
        cbs_pkg::CLS_BIT_REG: if (i == 4'h1) k = cbs_pkg::K_FETCH2;
        cbs_pkg::CLS_BIT_HL: begin
          if (i == 4'h1) k = cbs_pkg::K_FETCH2;
          else if (i == 4'h2) k = cbs_pkg::K_RD_HL;
        end
        cbs_pkg::CLS_BIT_IDX: begin
          if (i == 4'h1) k = cbs_pkg::K_FETCH2;
          else if (i == 4'h2) k = cbs_pkg::K_RD_OP;
          else if (i == 4'h3) k = cbs_pkg::K_FETCH3;
          else if (i == 4'h4) k = cbs_pkg::K_RD_IDX;
        end
        cbs_pkg::CLS_CALL, cbs_pkg::CLS_CALL_COND: begin
          // a false condition stops after the low address byte
          if (i == 4'h1) k = cbs_pkg::K_RD_OP; // RL6
          else if (c == cbs_pkg::CLS_CALL_COND && !cond) k = cbs_pkg::K_END; // RL6
          else if (i == 4'h2) k = cbs_pkg::K_RD_OP; // RL5
          else if (i == 4'h3) k = cbs_pkg::K_INT; // RL5
          else if (i == 4'h4) k = cbs_pkg::K_WR_HI; // RL5
          else if (i == 4'h5) k = cbs_pkg::K_WR_LO; // RL5
        end
        default: k = cbs_pkg::K_END;
      endcase
    end
    return k;
  endfunction

  assign start = instr_valid && (s.t == cbs_pkg::TS_IDLE);

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.t)
      cbs_pkg::TS_IDLE: begin
        if (instr_valid) begin
          next_s.cls = instr_class;
          next_s.cond = cond_true;
          next_s.ptr = program_counter;
          next_s.sp = stack_pointer;
          next_s.hl = memory_pointer_pair;
          next_s.base = use_index_y ? index_register_y : index_register_x;
          next_s.step = cbs_pkg::STEP_RESET;
          next_s.kind = cbs_pkg::K_FETCH1; // RL1
          next_s.t = cbs_pkg::TS_T1;
        end
      end
      cbs_pkg::TS_T1: next_s.t = cbs_pkg::TS_T2; // RL8
      cbs_pkg::TS_T2: next_s.t = cbs_pkg::TS_T3; // RL8
      cbs_pkg::TS_T3, cbs_pkg::TS_TI: begin
        // the displacement is captured at the close of the operand read
        if (s.t == cbs_pkg::TS_T3 && s.kind == cbs_pkg::K_RD_OP) begin
          next_s.disp = data_in; // RL7
        end
        if (s.kind inside {cbs_pkg::K_FETCH1, cbs_pkg::K_FETCH2, cbs_pkg::K_FETCH3,
                           cbs_pkg::K_RD_OP}) begin
          next_s.ptr = s.ptr + cbs_pkg::PTR_STEP;
        end
        next_s.step = s.step + 4'h1;
        next_s.kind = step_kind(s.cls, next_s.step, s.cond); // RL8
        if (next_s.kind == cbs_pkg::K_END) begin
          next_s.t = cbs_pkg::TS_IDLE;
          next_s.done = 1'b1;
        end else if (next_s.kind == cbs_pkg::K_INT) begin
          next_s.t = cbs_pkg::TS_TI; // RL3
        end else begin
          next_s.t = cbs_pkg::TS_T1;
        end
      end
      default: next_s = STATE_RESET;
    endcase
    next_s.data_out = cbs_pkg::DATA_RESET;
    unique case (next_s.kind)
      cbs_pkg::K_RD_HL: next_s.address = next_s.hl;
      cbs_pkg::K_RD_IDX: next_s.address = next_s.base + {{8{next_s.disp[7]}}, next_s.disp}; // RL7
      cbs_pkg::K_WR_HI: begin
        next_s.address = next_s.sp - cbs_pkg::STACK_STEP; // RL5
        next_s.data_out = next_s.ptr[15:8]; // RL5
      end
      cbs_pkg::K_WR_LO: begin
        next_s.address = next_s.sp - cbs_pkg::STACK_STEP - cbs_pkg::STACK_STEP; // RL5
        next_s.data_out = next_s.ptr[7:0]; // RL5
      end
      cbs_pkg::K_INT, cbs_pkg::K_END: next_s.address = cbs_pkg::ADDR_RESET; // RL3
      default: next_s.address = next_s.ptr;
    endcase
  end

  // pins join after the strobe map, so the map output never feeds back into next_s
  assign next_reg = {next_s[$bits(cbs_state_t)-1:9], next_pins};

  cbs_strobe_map u_map (
    .kind(next_s.kind),
    .read_strobe_b(next_pins[8]),
    .write_strobe_b(next_pins[7]),
    .memory_request_strobe_b(next_pins[6]),
    .io_request_strobe_b(next_pins[5]),
    .opcode_fetch_marker_b(next_pins[4]),
    .halt_b(next_pins[3]),
    .first_fetch_status_b(next_pins[2]),
    .address_valid(next_pins[1]),
    .data_oe(next_pins[0])
  );

  always_ff @(posedge clock or negedge reset_b_sync) begin
    if (!reset_b_sync) begin
      s <= STATE_RESET;
    end else begin
      s <= next_reg;
    end
  end

  assign instr_ready = (s.t == cbs_pkg::TS_IDLE);
  assign instr_done = s.done;
  assign address = s.address;
  assign data_out = s.data_out;
  assign {read_strobe_b, write_strobe_b, memory_request_strobe_b, io_request_strobe_b,
          opcode_fetch_marker_b, halt_b, first_fetch_status_b, address_valid, data_oe} = s.pins;

  a_first_fetch_pins: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL1
    (start && instr_class == cbs_pkg::CLS_SINGLE) |=>
      (!read_strobe_b && !memory_request_strobe_b && !opcode_fetch_marker_b &&
       !first_fetch_status_b && write_strobe_b && io_request_strobe_b && halt_b)[*3]
      ##1 instr_done)
    else $error("first fetch strobes or length wrong");
  a_second_fetch_status: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL2
    (s.kind == cbs_pkg::K_FETCH2) |-> (!opcode_fetch_marker_b && first_fetch_status_b &&
      !read_strobe_b && address == s.ptr))
    else $error("second fetch marker or status wrong");
  a_internal_quiet: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL3
    (s.t == cbs_pkg::TS_TI) |-> (s.pins == 9'h1FC))
    else $error("internal state not quiet");
  a_read_three_states: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL4
    (s.t == cbs_pkg::TS_T1 && s.kind inside {cbs_pkg::K_RD_OP, cbs_pkg::K_RD_HL,
      cbs_pkg::K_RD_IDX}) |-> (!read_strobe_b && !memory_request_strobe_b &&
      write_strobe_b && io_request_strobe_b && halt_b &&
      opcode_fetch_marker_b && first_fetch_status_b)[*3]
      ##1 (s.t != cbs_pkg::TS_T2))
    else $error("operand read not three states");
  a_call_stack_write: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL5
    (start && instr_class == cbs_pkg::CLS_CALL) |-> ##13 (!write_strobe_b &&
      address == $past(stack_pointer, 13) - 16'h0001) ##3 (!write_strobe_b &&
      address == $past(stack_pointer, 16) - 16'h0002) ##1 instr_done)
    else $error("call stack writes misplaced");
  a_call_false_ends: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL6
    (start && instr_class == cbs_pkg::CLS_CALL_COND && !cond_true) |=>
      write_strobe_b[*6] ##1 instr_done)
    else $error("false call did not end after two cycles");
  a_index_address: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL7
    (start && instr_class == cbs_pkg::CLS_ALU_IDX) |-> ##13 (s.t == cbs_pkg::TS_T1 &&
      s.kind == cbs_pkg::K_RD_IDX && address == ($past(use_index_y, 13) ?
      $past(index_register_y, 13) : $past(index_register_x, 13)) +
      {{8{s.disp[7]}}, s.disp}))
    else $error("indexed read at wrong time or address");
  a_tstate_order: assert property (@(posedge clock) disable iff (!reset_b_sync) // RL8
    (s.t == cbs_pkg::TS_T1) |=> (s.t == cbs_pkg::TS_T2) ##1 (s.t == cbs_pkg::TS_T3))
    else $error("t states out of order");
endmodule
`default_nettype wire

/* rtl/cbs_strobe_map.sv */
// maps a machine cycle kind onto the bus strobe levels
`timescale 1ns/1ps
`default_nettype none
module cbs_strobe_map (
  input wire cbs_pkg::cbs_kind_t kind,
  output logic read_strobe_b,
  output logic write_strobe_b,
  output logic memory_request_strobe_b,
  output logic io_request_strobe_b,
  output logic opcode_fetch_marker_b,
  output logic halt_b,
  output logic first_fetch_status_b,
  output logic address_valid,
  output logic data_oe
);
  always_comb begin
    read_strobe_b = 1'b1;
    write_strobe_b = 1'b1;
    memory_request_strobe_b = 1'b1;
    io_request_strobe_b = 1'b1;
    opcode_fetch_marker_b = 1'b1;
    halt_b = 1'b1;
    first_fetch_status_b = 1'b1;
    address_valid = 1'b0;
    data_oe = 1'b0;
    unique case (kind)
      cbs_pkg::K_FETCH1: begin
        read_strobe_b = 1'b0;
        memory_request_strobe_b = 1'b0;
        opcode_fetch_marker_b = 1'b0;
        first_fetch_status_b = 1'b0;
        address_valid = 1'b1;
      end
      cbs_pkg::K_FETCH2, cbs_pkg::K_FETCH3: begin
        read_strobe_b = 1'b0;
        memory_request_strobe_b = 1'b0;
        opcode_fetch_marker_b = 1'b0;
        address_valid = 1'b1;
      end
      cbs_pkg::K_RD_OP, cbs_pkg::K_RD_HL, cbs_pkg::K_RD_IDX: begin
        read_strobe_b = 1'b0;
        memory_request_strobe_b = 1'b0;
        address_valid = 1'b1;
      end
      cbs_pkg::K_WR_HI, cbs_pkg::K_WR_LO: begin
        write_strobe_b = 1'b0;
        memory_request_strobe_b = 1'b0;
        address_valid = 1'b1;
        data_oe = 1'b1;
      end
      // internal states and idle keep every strobe high and the bus floating
      default: begin
        address_valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* rtl/placeholder_none.sv */
// holds no logic: the sequencer and its strobe map carry the whole block
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/cbs_memory_model.sv */
// memory model standing on the far side of the sequencer's bus
`timescale 1ns/1ps
`default_nettype none
module cbs_memory_model (
  input wire logic clock,
  input wire logic [15:0] address,
  input wire logic read_strobe_b,
  input wire logic memory_request_strobe_b,
  output logic [7:0] data_in
);
  // no wait line exists on this bus, so every read completes in three states
  always @(posedge clock) begin
    if (!read_strobe_b && !memory_request_strobe_b) begin
      data_in <= address[7:0] ^ address[15:8] ^ 8'ha5;
    end else begin
      // released bus shows the inverse so a stale byte never passes for read data
      data_in <= ~(address[7:0] ^ address[15:8] ^ 8'ha5);
    end
  end
endmodule
`default_nettype wire

/* tb/test_cpu_bus_cycle_sequencer.sv */
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, want, got) begin n_checks++; if ((got) !== (want)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", name, want, got); end end
module test_cpu_bus_cycle_sequencer;
  typedef struct packed {logic [2:0] k; logic [15:0] a; logic [7:0] d;} cbs_mc_t;
  localparam logic [2:0] F1 = 3'h0, F2 = 3'h1, RD = 3'h2, TI = 3'h3, WR = 3'h4, DN = 3'h5;
  localparam logic [2:0] QT = 3'h6;
  // ready, done, address valid, data enable, then the seven strobes
  localparam logic [10:0] WANT [0:6] = '{11'h12a, 11'h12b, 11'h12f, 11'h07f, 11'h1cf,
    11'h67f, 11'h47f};
  logic clock, rst_b, instr_valid, cond_true, use_index_y;
  cbs_pkg::cbs_class_t instr_class;
  logic [15:0] program_counter, stack_pointer, memory_pointer_pair;
  logic [15:0] index_register_x, index_register_y, address;
  logic [7:0] data_in, data_out;
  logic instr_ready, instr_done, address_valid, data_oe, read_strobe_b, write_strobe_b;
  logic memory_request_strobe_b, io_request_strobe_b, opcode_fetch_marker_b, halt_b;
  logic first_fetch_status_b;
  cbs_mc_t exp_q[$];
  int n_errors = 0;
  int n_checks = 0;

  cbs_sequencer dut_u (.clock(clock), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_class(instr_class), .cond_true(cond_true), .use_index_y(use_index_y),
    .program_counter(program_counter), .stack_pointer(stack_pointer),
    .memory_pointer_pair(memory_pointer_pair), .index_register_x(index_register_x),
    .index_register_y(index_register_y), .data_in(data_in), .instr_ready(instr_ready),
    .instr_done(instr_done), .address(address), .address_valid(address_valid),
    .data_out(data_out), .data_oe(data_oe), .read_strobe_b(read_strobe_b),
    .write_strobe_b(write_strobe_b), .memory_request_strobe_b(memory_request_strobe_b),
    .io_request_strobe_b(io_request_strobe_b), .opcode_fetch_marker_b(opcode_fetch_marker_b),
    .halt_b(halt_b), .first_fetch_status_b(first_fetch_status_b));

  cbs_memory_model mem_u (.clock(clock), .address(address), .read_strobe_b(read_strobe_b),
    .memory_request_strobe_b(memory_request_strobe_b), .data_in(data_in));

  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'ha5;
  endfunction

  task automatic add(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({k, a, d});
  endtask

  task automatic plan(input cbs_pkg::cbs_class_t cls, input logic cond);
    logic [15:0] pc, base, ret, disp;
    logic [7:0] d8;
    pc = program_counter;
    base = use_index_y ? index_register_y : index_register_x;
    d8 = mem_byte(pc + 16'h0002);
    disp = {{8{d8[7]}}, d8};
    ret = pc + 16'h0003;
    exp_q.delete();
    add(F1, pc, 8'h00);
    case (cls)
      cbs_pkg::CLS_ADD16: repeat (4) add(TI, 16'h0000, 8'h00);
      cbs_pkg::CLS_ADD_IDX16, cbs_pkg::CLS_ADC16: begin
        add(F2, pc + 16'h0001, 8'h00);
        repeat (4) add(TI, 16'h0000, 8'h00);
      end
      cbs_pkg::CLS_ALU_REG: add(TI, 16'h0000, 8'h00);
      cbs_pkg::CLS_ALU_IMM: add(RD, pc + 16'h0001, 8'h00);
      cbs_pkg::CLS_ALU_HL: add(RD, memory_pointer_pair, 8'h00);
      cbs_pkg::CLS_BIT_REG: add(F2, pc + 16'h0001, 8'h00);
      cbs_pkg::CLS_BIT_HL: begin
        add(F2, pc + 16'h0001, 8'h00);
        add(RD, memory_pointer_pair, 8'h00);
      end
      cbs_pkg::CLS_ALU_IDX, cbs_pkg::CLS_BIT_IDX: begin
        add(F2, pc + 16'h0001, 8'h00);
        add(RD, pc + 16'h0002, 8'h00);
        if (cls == cbs_pkg::CLS_ALU_IDX) repeat (3) add(TI, 16'h0000, 8'h00);
        else add(F2, pc + 16'h0003, 8'h00);
        add(RD, base + disp, 8'h00);
      end
      cbs_pkg::CLS_CALL, cbs_pkg::CLS_CALL_COND: begin
        add(RD, pc + 16'h0001, 8'h00);
        if (cls == cbs_pkg::CLS_CALL || cond) begin
          add(RD, pc + 16'h0002, 8'h00);
          add(TI, 16'h0000, 8'h00);
          add(WR, stack_pointer - 16'h0001, ret[15:8]);
          add(WR, stack_pointer - 16'h0002, ret[7:0]);
        end
      end
      default: ;
    endcase
  endtask

  task automatic chk(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
    `CHK("strobes", WANT[k], {instr_ready, instr_done, address_valid, data_oe, read_strobe_b,
      write_strobe_b, memory_request_strobe_b, io_request_strobe_b, opcode_fetch_marker_b,
      halt_b, first_fetch_status_b})
    `CHK("address", a, address)
    `CHK("data_out", d, data_out)
  endtask

  // chained runs reuse the inputs already standing, so back to back needs no new setup
  task automatic run(input cbs_pkg::cbs_class_t cls, input logic cond, input bit chained,
    input bit chain_next);
    cbs_mc_t m;
    if (!chained) begin
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_class <= cls;
      cond_true <= cond;
    end
    // planned only once the caller's non-blocking setup has landed
    plan(cls, cond);
    @(posedge clock);
    instr_valid <= 1'b0;
    foreach (exp_q[i]) begin
      m = exp_q[i];
      repeat (m.k == TI ? 1 : 3) begin
        @(negedge clock);
        chk(m.k, m.a, m.d);
      end
    end
    @(posedge clock);
    if (chain_next) instr_valid <= 1'b1;
    @(negedge clock);
    chk(DN, 16'h0000, 8'h00);
  endtask

  task automatic t_call();
    @(posedge clock);
    program_counter <= 16'hfffe;
    stack_pointer <= 16'h0001;
    run(cbs_pkg::CLS_CALL, 1'b0, 1'b0, 1'b0);
    run(cbs_pkg::CLS_CALL_COND, 1'b1, 1'b0, 1'b0);
    $display("test call done");
  endtask

  task automatic t_cond_false();
    run(cbs_pkg::CLS_CALL_COND, 1'b0, 1'b0, 1'b1);
    run(cbs_pkg::CLS_CALL_COND, 1'b0, 1'b1, 1'b0);
    $display("test false condition done");
  endtask

  task automatic t_indexed();
    @(posedge clock);
    program_counter <= 16'h1000;
    index_register_x <= 16'h0020;
    index_register_y <= 16'hfff0;
    use_index_y <= 1'b0;
    run(cbs_pkg::CLS_ALU_IDX, 1'b0, 1'b0, 1'b0);
    @(posedge clock);
    program_counter <= 16'h3080;
    use_index_y <= 1'b1;
    run(cbs_pkg::CLS_ALU_IDX, 1'b0, 1'b0, 1'b0);
    run(cbs_pkg::CLS_BIT_IDX, 1'b0, 1'b0, 1'b0);
    $display("test indexed done");
  endtask

  task automatic t_groups();
    cbs_pkg::cbs_class_t grp [0:8];
    grp = '{cbs_pkg::CLS_SINGLE, cbs_pkg::CLS_ADD16, cbs_pkg::CLS_ADD_IDX16,
      cbs_pkg::CLS_ADC16, cbs_pkg::CLS_ALU_REG, cbs_pkg::CLS_ALU_IMM, cbs_pkg::CLS_ALU_HL,
      cbs_pkg::CLS_BIT_REG, cbs_pkg::CLS_BIT_HL};
    @(posedge clock);
    memory_pointer_pair <= 16'h8001;
    foreach (grp[i]) run(grp[i], 1'b0, 1'b0, 1'b0);
    $display("test groups done");
  endtask

  task automatic t_reset();
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_class <= cbs_pkg::CLS_CALL;
    @(posedge clock);
    instr_valid <= 1'b0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b0;
    @(negedge clock);
    chk(QT, 16'h0000, 8'h00);
    @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk(QT, 16'h0000, 8'h00);
    run(cbs_pkg::CLS_SINGLE, 1'b0, 1'b0, 1'b0);
    $display("test reset done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (3000) @(posedge clock);
    n_errors++;
    $display("ERROR watchdog expected end seen hang");
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_class = cbs_pkg::CLS_SINGLE;
    cond_true = 1'b0;
    use_index_y = 1'b0;
    program_counter = 16'h0100;
    stack_pointer = 16'h8000;
    memory_pointer_pair = 16'h4000;
    index_register_x = 16'h0000;
    index_register_y = 16'h0000;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (3) @(posedge clock);
    t_call();
    t_cond_false();
    t_indexed();
    t_groups();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
